// *** xhc_cap_pkg.sv ***
/*
 * Constants, field layout and types for the structural capability bank.
 * Assumes one core clock domain and a word-wide memory-mapped read port.
 */
// What this block does
// - Each capability register sits at a fixed offset from the base of the mapped space and is read-only.
// - The slot count field of the first structural register reads 32.
// - The interrupter count field of the first structural register reads 8.
// - Each interrupter owns one message vector; a round-robin arbiter shared by all interrupters decides when that vector fires.
// - Exactly as many interrupter register sets are addressable as the interrupter count reports.
// - The top byte of the first structural register gives the root port count, 8 or 4 by variant, and that many port sets are addressable.
// - The low nibble of the second structural register reads an isochronous threshold of 1 microframe.
// - Bits 7 to 4 of the second structural register give a segment table exponent of 1.
// - The scratchpad restore bit reads 1, so scratchpad space is never freed between power events.
// - The top five bits of the second structural register report 4 scratchpad buffers for software to reserve.
// - The low byte of the third structural register reports a U1 exit latency of 0.
// - The upper half of the third structural register reports a U2 exit latency of 0.
// - Bit 0 of the feature register reads 1 for 64-bit pointer fields.
// - Bit 1 of the feature register reads 1 for bandwidth negotiation.
// - Bit 2 of the feature register reads 1 and contexts are 64 bytes.
package xhc_cap_pkg;

	localparam int unsigned DATA_W = 32;
	localparam int unsigned ADDR_W = 8;

	// Byte offsets from the base of the mapped space
	localparam logic [ADDR_W-1:0] OFS_LIMITS   = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_SCHED    = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_LATENCY  = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_FEATURES = 8'h10;

	// Field positions
	localparam int unsigned SLOT_LSB  = 0;
	localparam int unsigned INTR_LSB  = 8;
	localparam int unsigned PORT_LSB  = 24;
	localparam int unsigned IST_LSB   = 0;
	localparam int unsigned ERST_LSB  = 4;
	localparam int unsigned SPR_BIT   = 26;
	localparam int unsigned SPB_LSB   = 27;
	localparam int unsigned U1_LSB    = 0;
	localparam int unsigned U2_LSB    = 16;
	localparam int unsigned A64_BIT   = 0;
	localparam int unsigned BWN_BIT   = 1;
	localparam int unsigned CSZ_BIT   = 2;

	// Field values
	localparam logic [7:0]  SLOT_VAL    = 8'h20;
	localparam logic [10:0] INTR_VAL    = 11'h008;
	localparam logic [7:0]  PORTS_EIGHT = 8'h08;
	localparam logic [7:0]  PORTS_FOUR  = 8'h04;
	localparam logic [3:0]  IST_VAL     = 4'h1;
	localparam logic [3:0]  ERST_VAL    = 4'h1;
	localparam logic        SPR_VAL     = 1'h1;
	localparam logic [4:0]  SPB_VAL     = 5'h04;
	localparam logic [7:0]  U1_VAL      = 8'h00;
	localparam logic [15:0] U2_VAL      = 16'h0000;
	localparam logic        A64_VAL     = 1'h1;
	localparam logic        BWN_VAL     = 1'h1;
	localparam logic        CSZ_VAL     = 1'h1;
	localparam logic [6:0]  CTX_BYTES_L = 7'h40;
	localparam logic [6:0]  CTX_BYTES_S = 7'h20;

	typedef enum logic {VAR_EIGHT = 1'b0, VAR_FOUR = 1'b1} port_variant_e;
	typedef enum logic {ARB_IDLE = 1'b0, ARB_SENT = 1'b1} arb_state_e;

endpackage : xhc_cap_pkg

// *** cap_fields_if.sv ***
/*
 * Carries the packed capability words from the constant source to the bank.
 * Assumes both ends sit in the same module hierarchy on one clock.
 */
`timescale 1ns/1ns
`default_nettype none
interface cap_fields_if;
	logic [31:0] word_limits;
	logic [31:0] word_sched;
	logic [31:0] word_latency;
	logic [31:0] word_features;
	modport source (output word_limits, word_sched, word_latency, word_features);
	modport sink   (input  word_limits, word_sched, word_latency, word_features);
endinterface : cap_fields_if
`default_nettype wire

// *** cap_field_source.sv ***
/*
 * Packs the fixed capability fields into their four words.
 * Assumes the variant is fixed at build time.
 */
`timescale 1ns/1ns
`default_nettype none
module cap_field_source
	import xhc_cap_pkg::*;
#(
	parameter port_variant_e VARIANT = VAR_EIGHT
) (
	cap_fields_if.source f	// Packed words out
);
	logic [7:0] ports;

	assign ports = (VARIANT == VAR_FOUR) ? PORTS_FOUR : PORTS_EIGHT;

	// Unnamed bits stay zero
	always_comb begin
		f.word_limits                    = '0;
		f.word_limits[SLOT_LSB +: 8]     = SLOT_VAL;
		f.word_limits[INTR_LSB +: 11]    = INTR_VAL;
		f.word_limits[PORT_LSB +: 8]     = ports;
		f.word_sched                     = '0;
		f.word_sched[IST_LSB +: 4]       = IST_VAL;
		f.word_sched[ERST_LSB +: 4]      = ERST_VAL;
		f.word_sched[SPR_BIT]            = SPR_VAL;
		f.word_sched[SPB_LSB +: 5]       = SPB_VAL;
		f.word_latency                   = '0;
		f.word_latency[U1_LSB +: 8]      = U1_VAL;
		f.word_latency[U2_LSB +: 16]     = U2_VAL;
		f.word_features                  = '0;
		f.word_features[A64_BIT]         = A64_VAL;
		f.word_features[BWN_BIT]         = BWN_VAL;
		f.word_features[CSZ_BIT]         = CSZ_VAL;
	end
endmodule : cap_field_source
`default_nettype wire

// *** index_limit_check.sv ***
/*
 * Says whether an index falls below a reported count.
 * Assumes both inputs come from logic on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none
module index_limit_check #(
	parameter int unsigned IDX_W = 8
) (
	input  wire logic [IDX_W-1:0] idx,	// Index asked about
	input  wire logic [IDX_W-1:0] limit,	// Reported count
	output logic                  ok	// Index is addressable
);
	assign ok = (idx < limit);
endmodule : index_limit_check
`default_nettype wire

// *** xhc_structural_capability_regs.sv ***
/*
 * Read-only structural capability bank with set decode and vector steering.
 * Assumes all inputs come from logic on core_clk; one access per cycle.
 */
`timescale 1ns/1ns
`default_nettype none
module xhc_structural_capability_regs
	import xhc_cap_pkg::*;
#(
	parameter port_variant_e VARIANT  = VAR_EIGHT,
	parameter int unsigned   INTR_MAX = 8
) (
	input  wire logic              core_clk,	// Core clock, 50 MHz
	input  wire logic              rst,	// Async reset, active high
	input  wire logic              mmio_rd,	// Read strobe
	input  wire logic              mmio_wr,	// Write strobe
	input  wire logic [ADDR_W-1:0] mmio_addr,	// Byte address from base
	input  wire logic [DATA_W-1:0] mmio_wdata,	// Write data, discarded
	output logic      [DATA_W-1:0] mmio_rdata,	// Read data
	output logic                   mmio_ack,	// Access answered
	output logic                   mmio_hit,	// Address is in this bank
	input  wire logic [7:0]        slot_sel,	// Slot index asked about
	output logic                   slot_ok,	// Slot index valid
	input  wire logic [7:0]        port_sel,	// Port index asked about
	output logic                   port_ok,	// Port set addressable
	input  wire logic [10:0]       intr_sel,	// Interrupter index asked about
	output logic                   intr_ok,	// Interrupter set addressable
	input  wire logic [INTR_MAX-1:0] intr_event,	// Per-interrupter event pulse
	input  wire logic [INTR_MAX-1:0] intr_hold,	// Per-interrupter moderation hold
	output logic                   msix_req,	// Vector message request
	output logic      [10:0]       msix_vector,	// Vector number
	output logic      [7:0]        root_ports,	// Root port count
	output logic      [4:0]        scratch_bufs,	// Scratchpad buffers needed
	output logic      [15:0]       event_segment_table_exponent_entries,	// Segment table entries
	output logic      [6:0]        ctx_bytes,	// Context structure size
	output logic                   addr64_en	// Upper pointer halves live
);
	localparam int unsigned IV_W = (INTR_MAX > 1) ? $clog2(INTR_MAX) : 1;

	// ------------------------------------------------------------
	// Constant words
	// ------------------------------------------------------------
	cap_fields_if fields ();

	cap_field_source #(
		.VARIANT (VARIANT)
	) u_source (
		.f (fields)
	);

	logic [7:0]  ports_rep;
	logic [10:0] intrs_rep;
	logic [7:0]  slots_rep;

	assign ports_rep = fields.word_limits[PORT_LSB +: 8];
	assign intrs_rep = fields.word_limits[INTR_LSB +: 11];
	assign slots_rep = fields.word_limits[SLOT_LSB +: 8];

	// ------------------------------------------------------------
	// Set decode
	// ------------------------------------------------------------
	logic slot_in;
	logic port_in;
	logic intr_in;

	index_limit_check #(
		.IDX_W (8)
	) u_slot_chk (
		.idx   (slot_sel),
		.limit (slots_rep),
		.ok    (slot_in)
	);

	index_limit_check #(
		.IDX_W (8)
	) u_port_chk (
		.idx   (port_sel),
		.limit (ports_rep),
		.ok    (port_in)
	);

	index_limit_check #(
		.IDX_W (11)
	) u_intr_chk (
		.idx   (intr_sel),
		.limit (intrs_rep),
		.ok    (intr_in)
	);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [DATA_W-1:0]   rdata;
		logic                ack;
		logic                hit;
		logic                slot_ok;
		logic                port_ok;
		logic                intr_ok;
		logic [INTR_MAX-1:0] pend;
		logic [IV_W-1:0]     rr;
		arb_state_e          arb;
		logic                req;
		logic [10:0]         vec;
		logic [7:0]          ports;
		logic [4:0]          bufs;
		logic [15:0]         erst;
		logic [6:0]          ctx;
		logic                a64;
	} state_s;

	state_s st_q;
	state_s st_d;

	logic                unused_wdata;
	logic [INTR_MAX-1:0] avail;
	logic                found;
	logic [IV_W-1:0]     pick;
	logic [IV_W-1:0]     cand;
	logic [IV_W:0]       cand_w;

	// Write data has nowhere to go
	assign unused_wdata = ^mmio_wdata;

	// Held interrupters keep their pending bit; moderation only delays
	assign avail = st_q.pend & ~intr_hold;

	// Round-robin search starting at the slot after the last winner
	always_comb begin
		found  = 1'b0;
		pick   = '0;
		cand   = '0;
		cand_w = '0;
		for (int i = 0; i < INTR_MAX; i++) begin
			cand_w = (IV_W + 1)'({1'b0, st_q.rr} + (IV_W + 1)'(i));
			if (cand_w >= (IV_W + 1)'(INTR_MAX)) begin
				cand_w = (IV_W + 1)'(cand_w - (IV_W + 1)'(INTR_MAX));
			end
			cand = cand_w[IV_W-1:0];
			if (!found && avail[cand]) begin
				found = 1'b1;
				pick  = cand;
			end
		end
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		st_d = st_q;

		// Register read path; address low bits select nothing finer than a word
		st_d.ack   = mmio_rd | mmio_wr;
		st_d.hit   = 1'b0;
		st_d.rdata = '0;
		if (mmio_rd || mmio_wr) begin
			unique case ({mmio_addr[ADDR_W-1:2], 2'b00})
				OFS_LIMITS: begin
					st_d.hit = 1'b1;
					if (mmio_rd) begin
						st_d.rdata = fields.word_limits;
					end
				end
				OFS_SCHED: begin
					st_d.hit = 1'b1;
					if (mmio_rd) begin
						st_d.rdata = fields.word_sched;
					end
				end
				OFS_LATENCY: begin
					st_d.hit = 1'b1;
					if (mmio_rd) begin
						st_d.rdata = fields.word_latency;
					end
				end
				OFS_FEATURES: begin
					st_d.hit = 1'b1;
					if (mmio_rd) begin
						st_d.rdata = fields.word_features;
					end
				end
				default: begin
					st_d.hit = 1'b0;
				end
			endcase
		end

		// Set decode, one cycle behind the query
		st_d.slot_ok = slot_in;
		st_d.port_ok = port_in;
		st_d.intr_ok = intr_in;

		// Fixed limits handed to the rest of the controller
		st_d.ports = ports_rep;
		st_d.bufs  = fields.word_sched[SPB_LSB +: 5];
		st_d.erst  = 16'h0001 << fields.word_sched[ERST_LSB +: 4];
		st_d.ctx   = fields.word_features[CSZ_BIT] ? CTX_BYTES_L : CTX_BYTES_S;
		st_d.a64   = fields.word_features[A64_BIT];

		// One message per two cycles; a new event on the winner is kept
		st_d.req = 1'b0;
		unique case (st_q.arb)
			ARB_IDLE: begin
				if (found) begin
					st_d.req        = 1'b1;
					st_d.vec        = 11'(pick);
					st_d.pend[pick] = 1'b0;
					st_d.rr         = (pick == IV_W'(INTR_MAX - 1)) ? '0 : IV_W'(pick + 1'b1);
					st_d.arb        = ARB_SENT;
				end
			end
			ARB_SENT: begin
				st_d.arb = ARB_IDLE;
			end
		endcase
		st_d.pend = st_d.pend | intr_event;
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign mmio_rdata       = st_q.rdata;
	assign mmio_ack         = st_q.ack;
	assign mmio_hit         = st_q.hit;
	assign slot_ok          = st_q.slot_ok;
	assign port_ok          = st_q.port_ok;
	assign intr_ok          = st_q.intr_ok;
	assign msix_req         = st_q.req;
	assign msix_vector      = st_q.vec;
	assign root_ports       = st_q.ports;
	assign scratch_bufs     = st_q.bufs;
	assign event_segment_table_exponent_entries = st_q.erst;
	assign ctx_bytes        = st_q.ctx;
	assign addr64_en        = st_q.a64;

endmodule : xhc_structural_capability_regs
`default_nettype wire

// *** cap_bank_props.sv ***
/*
 * Port checker for the capability bank.
 * Assumes one clock; bound from the testbench.
 */
`timescale 1ns/1ns
`default_nettype none
module cap_bank_props
	import xhc_cap_pkg::*;
#(
	parameter port_variant_e	VARIANT = VAR_EIGHT,
	parameter int unsigned		INTR_MAX = 8
) (
	input wire logic		core_clk,	// clock
	input wire logic		rst,	// reset
	input wire logic		mmio_rd,	// read
	input wire logic		mmio_wr,	// write
	input wire logic [ADDR_W-1:0]	mmio_addr,	// address
	input wire logic [DATA_W-1:0]	mmio_rdata,	// data
	input wire logic		mmio_ack,	// ack
	input wire logic		mmio_hit,	// hit
	input wire logic [7:0]		slot_sel,	// slot
	input wire logic		slot_ok,	// slot ok
	input wire logic [7:0]		port_sel,	// port
	input wire logic		port_ok,	// port ok
	input wire logic [10:0]		intr_sel,	// interrupter
	input wire logic		intr_ok,	// intr ok
	input wire logic		msix_req,	// request
	input wire logic [10:0]		msix_vector,	// vector
	input wire logic [7:0]		root_ports,	// ports
	input wire logic [4:0]		scratch_bufs,	// buffers
	input wire logic [15:0]		event_segment_table_exponent_entries,	// entries
	input wire logic [6:0]		ctx_bytes,	// context
	input wire logic		addr64_en	// 64-bit
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	logic [7:0]	np;
	logic		rd_map;
	assign np = (VARIANT == VAR_FOUR) ? 8'h04 : 8'h08;
	assign rd_map = mmio_rd && mmio_addr[7:2] inside {[6'h01:6'h04]};
	// ----------------------------------------
	// Bus answers
	// ----------------------------------------
	a_ack_timing: assert property (!$past(rst) |-> mmio_ack == $past(mmio_rd || mmio_wr))
		else $error("ack not one cycle after access");
	a_hit_decode: assert property (mmio_ack |-> mmio_hit == ($past(mmio_addr[7:2]) inside {[6'h01:6'h04]}))
		else $error("hit decode wrong");
	a_limits_word: assert property (mmio_rd && mmio_addr[7:2] == 6'h01 |=> mmio_rdata == {np, 24'h000820})
		else $error("limits word wrong");
	a_sched_word: assert property (mmio_rd && mmio_addr[7:2] == 6'h02 |=> mmio_rdata == 32'h24000011)
		else $error("scheduling word wrong");
	a_latency_zero: assert property (mmio_rd && mmio_addr[7:2] == 6'h03 |=> mmio_rdata == 32'h0)
		else $error("latency word wrong");
	a_feature_bits: assert property (mmio_rd && mmio_addr[7:2] == 6'h04 |=> mmio_rdata == 32'h7)
		else $error("feature word wrong");
	a_quiet_zero: assert property (!rd_map |=> mmio_rdata == 32'h0)
		else $error("data without mapped read");
	// ----------------------------------------
	// Sets, vectors, constants
	// ----------------------------------------
	a_index_ok: assert property (!$past(rst) |-> slot_ok == ($past(slot_sel) < 8'h20) && port_ok == ($past(port_sel) < np) && intr_ok == ($past(intr_sel) < 11'h008))
		else $error("index answer wrong");
	a_req_spacing: assert property (msix_req |=> !msix_req)
		else $error("requests too close");
	a_vector_range: assert property (msix_req |-> msix_vector < INTR_MAX)
		else $error("vector out of range");
	a_const_out: assert property (!$past(rst) |-> root_ports == np && scratch_bufs == 5'h04 && event_segment_table_exponent_entries == 16'h0002 && ctx_bytes == 7'h40 && addr64_en)
		else $error("constant output wrong");
	c_read_hit: cover property (mmio_ack && mmio_hit);
	c_write: cover property (mmio_wr ##1 mmio_ack);
	c_msix: cover property (msix_req);
endmodule : cap_bank_props
`default_nettype wire

// *** testbench.sv ***
/*
 * Self-checking bench for the capability bank.
 * Assumes the bank is built for eight ports and eight interrupters.
 */
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import xhc_cap_pkg::*;
	typedef struct packed {logic [31:0] d; logic h;} note_s;
	logic core_clk = 1'b0, rst = 1'b1, mmio_rd = 1'b0, mmio_wr = 1'b0;
	logic [7:0] mmio_addr = 8'h00, slot_sel = 8'h00, port_sel = 8'h00;
	logic [31:0] mmio_wdata = 32'h0, mmio_rdata;
	logic [10:0] intr_sel = 11'h000, msix_vector;
	logic [7:0] intr_event = 8'h00, intr_hold = 8'h00, root_ports;
	logic mmio_ack, mmio_hit, slot_ok, port_ok, intr_ok, msix_req, addr64_en;
	logic [4:0] scratch_bufs;
	logic [15:0] event_segment_table_exponent_entries;
	logic [6:0] ctx_bytes;
	note_s q[$];
	note_s nt;
	logic [10:0] vq[$];
	int err_total = 0, n_checks = 0, seed;
	int idx_list[8] = '{0, 3, 4, 7, 8, 31, 32, 255};
	always #10 core_clk = ~core_clk;
	xhc_structural_capability_regs u_dut (.core_clk(core_clk), .rst(rst), .mmio_rd(mmio_rd),
		.mmio_wr(mmio_wr), .mmio_addr(mmio_addr), .mmio_wdata(mmio_wdata),
		.mmio_rdata(mmio_rdata), .mmio_ack(mmio_ack), .mmio_hit(mmio_hit),
		.slot_sel(slot_sel), .slot_ok(slot_ok), .port_sel(port_sel), .port_ok(port_ok),
		.intr_sel(intr_sel), .intr_ok(intr_ok), .intr_event(intr_event),
		.intr_hold(intr_hold), .msix_req(msix_req), .msix_vector(msix_vector),
		.root_ports(root_ports), .scratch_bufs(scratch_bufs),
		.event_segment_table_exponent_entries(event_segment_table_exponent_entries), .ctx_bytes(ctx_bytes), .addr64_en(addr64_en));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	function automatic logic [31:0] word_of(input logic [7:0] a);
		case (a[7:2])
			6'h01: word_of = 32'h08000820;
			6'h02: word_of = 32'h24000011;
			6'h04: word_of = 32'h00000007;
			default: word_of = 32'h0;
		endcase
	endfunction : word_of
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	// Back to back: each call is one access on the next edge
	task automatic bus(input logic w, input logic [7:0] a);
		@(posedge core_clk);
		mmio_rd <= !w;
		mmio_wr <= w;
		mmio_addr <= a;
		mmio_wdata <= $random(seed);
		q.push_back('{w ? 32'h0 : word_of(a), a[7:2] inside {[6'h01:6'h04]}});
	endtask : bus
	task automatic test_done;
		$display("checks=%0d errors=%0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : test_done
	// ----------------------------------------
	// Monitor
	// ----------------------------------------
	always @(posedge core_clk) begin
		if (!rst && mmio_ack === 1'b1) begin
			if (q.size() == 0)
				err_total++;
			else begin
				nt = q.pop_front();
				chk(mmio_rdata, nt.d);
				chk(32'(mmio_hit), 32'(nt.h));
			end
		end
		if (!rst && msix_req === 1'b1) begin
			if (vq.size() == 0)
				err_total++;
			else
				chk(32'(msix_vector), 32'(vq.pop_front()));
		end
	end
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		seed = 32'h6adcc96a;
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		repeat (2) @(posedge core_clk);
		#1;
		chk(32'({root_ports, scratch_bufs, ctx_bytes, addr64_en}), 32'h00010481);
		chk(32'(event_segment_table_exponent_entries), 32'h2);
		// Read, write, read again: the write must leave no trace
		for (int a = 0; a < 32; a += 4) begin
			bus(1'b0, 8'(a));
			bus(1'b1, 8'(a));
			bus(1'b0, 8'(a));
		end
		for (int i = 0; i < 200; i++)
			bus(1'($random(seed)), 8'($random(seed)));
		@(posedge core_clk);
		mmio_rd <= 1'b0;
		mmio_wr <= 1'b0;
		foreach (idx_list[k]) begin
			slot_sel <= 8'(idx_list[k]);
			port_sel <= 8'(idx_list[k]);
			intr_sel <= 11'(idx_list[k]);
			repeat (2) @(posedge core_clk);
			#1;
			chk({slot_ok, port_ok, intr_ok}, {slot_sel < 8'h20, port_sel < 8'h08, intr_sel < 11'h008});
		end
		// A held interrupter keeps its event pending
		@(posedge core_clk);
		intr_hold <= 8'h04;
		intr_event <= 8'h04;
		@(posedge core_clk);
		intr_event <= 8'h00;
		repeat (6) @(posedge core_clk);
		vq.push_back(11'h002);
		intr_hold <= 8'h00;
		repeat (4) @(posedge core_clk);
		vq.push_back(11'h005);
		vq.push_back(11'h001);
		intr_event <= 8'h22;
		@(posedge core_clk);
		intr_event <= 8'h00;
		for (int i = 0; i < 50 && (vq.size() + q.size()) > 0; i++)
			@(posedge core_clk);
		chk(32'(vq.size() + q.size()), 32'h0);
		test_done();
	end
	initial begin
		#100000;
		err_total++;
		test_done();
	end
endmodule : testbench
bind xhc_structural_capability_regs cap_bank_props #(.VARIANT(VARIANT), .INTR_MAX(INTR_MAX))
	u_props (.core_clk(core_clk), .rst(rst), .mmio_rd(mmio_rd), .mmio_wr(mmio_wr),
	.mmio_addr(mmio_addr), .mmio_rdata(mmio_rdata), .mmio_ack(mmio_ack),
	.mmio_hit(mmio_hit), .slot_sel(slot_sel), .slot_ok(slot_ok), .port_sel(port_sel),
	.port_ok(port_ok), .intr_sel(intr_sel), .intr_ok(intr_ok), .msix_req(msix_req),
	.msix_vector(msix_vector), .root_ports(root_ports), .scratch_bufs(scratch_bufs),
	.event_segment_table_exponent_entries(event_segment_table_exponent_entries), .ctx_bytes(ctx_bytes), .addr64_en(addr64_en));
`default_nettype wire
